// ---- rtl/twi_master.sv ----
// Purpose: master controller driving a two-wire open-drain bus
// Assumes: 10 MHz clock, pull-ups on both lines, commands from local logic
// Notes:   commands are START, WRITE byte, READ byte (ack/nack), STOP
//
// Functional notes
// RULE_01 - sender keeps data line steady while clock line is high
// RULE_02 - data change during clock high mid-transfer aborts the transfer
// RULE_03 - sender changes data line only while clock line is low
// RULE_04 - start, bytes msb first with ack after eight bits, then stop
// RULE_05 - slave may hold clock low; master waits for real release
// RULE_06 - start is data falling while clock high, master only
// RULE_07 - stop is data rising while clock high, ends the transfer
// RULE_08 - bus busy from start until an interval after stop
// RULE_09 - received bytes become invalid once a stop is issued
// RULE_10 - repeated start allowed mid-transfer without a stop
// RULE_11 - ninth clock pulse is the ack; transmitter releases data
// RULE_12 - receiver pulls data low during ack pulse to accept
// RULE_13 - master receiver leaves last byte unacknowledged
// RULE_14 - full or busy receiver answers with negative acknowledge
// RULE_15 - seven address bits then direction bit, one means read
// RULE_16 - addressed device acknowledges and takes its direction role
// RULE_17 - general call uses address zero, second byte gives meaning
// RULE_18 - master aborts when sampled data differs from driven data
// RULE_19 - clock follows slowest master or stalling slave
// RULE_20 - master losing arbitration releases the bus at once
// RULE_21 - master starts, clocks and ends every transfer
// RULE_22 - lines are only pulled low or released, never driven high
`timescale 1ns/10ps
module twi_master #(
  parameter int unsigned FIFO_DEPTH = twi_pkg::FIFO_DEPTH
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_cmd_valid,
  output logic            o_cmd_ready,
  input  wire logic [1:0] i_cmd,
  input  wire logic [7:0] i_cmd_data,
  input  wire logic       i_cmd_nack,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  output logic      [7:0] o_rx_data,
  output logic            o_done,
  output logic            o_got_nack,
  output logic            o_arb_lost,
  output logic            o_bus_error,
  output logic            o_bus_busy,
  input  wire logic       i_scl,
  output logic            o_scl,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe
);
  // ---------------------------------------------------------------------
  // types and signals
  // ---------------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_START = 8'h02,
    ST_LOW   = 8'h04,
    ST_HIGH  = 8'h08,
    ST_STOP0 = 8'h10,
    ST_STOP1 = 8'h20,
    ST_RSTA  = 8'h40,
    ST_HOLD  = 8'h80
  } state_e;

  localparam int unsigned CW = 8;

  state_e        state_reg;
  logic [CW-1:0] cnt_reg;
  logic [3:0]    bit_reg;
  logic [7:0]    sh_reg;
  logic          rd_reg;
  logic          nack_reg;
  logic          own_reg;
  logic          sda_low_reg;
  logic          scl_low_reg;
  logic          scl_s;
  logic          sda_s;
  logic          scl_d_reg;
  logic          sda_d_reg;
  logic          start_det;
  logic          stop_det;
  logic          busy_reg;
  logic [CW-1:0] free_reg;
  logic          fifo_ready;
  logic          push;
  logic          flush;
  logic          cnt_done;
  logic          lose;
  logic          tx_phase;

  // ---------------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------------
  twi_sync u_sync_scl (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_d     (i_scl),
    .o_q     (scl_s)
  );

  twi_sync u_sync_sda (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_d     (i_sda),
    .o_q     (sda_s)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (i_ce) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // edge flops reset high like the idle lines, so release shows no false start
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;  // RULE_06
  assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;  // RULE_07

  // ---------------------------------------------------------------------
  // bus busy tracking
  // ---------------------------------------------------------------------
  // busy lingers a bus-free time after stop so a new start waits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
      free_reg <= '0;
    end else if (i_ce) begin
      if (start_det) begin
        busy_reg <= 1'b1;  // RULE_08
        free_reg <= '0;
      end else if (stop_det) begin
        free_reg <= CW'(twi_pkg::FREE_CYC);
      end else if (free_reg != '0) begin
        free_reg <= free_reg - 1'b1;
        if (free_reg == CW'(1)) busy_reg <= 1'b0;  // RULE_08
      end
    end
  end
  assign o_bus_busy = busy_reg || (free_reg != '0);

  // ---------------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------------
  // only bits sent from this end are compared: the ack of a write and the
  // data bits of a read are driven from the far side
  assign tx_phase = rd_reg ? (bit_reg == 4'd8) : (bit_reg < 4'd8);
  assign lose     = state_reg == ST_HIGH && scl_s && !sda_low_reg && !sda_s && tx_phase;  // RULE_18

  // ---------------------------------------------------------------------
  // bit engine
  // ---------------------------------------------------------------------
  assign cnt_done    = (cnt_reg == '0);
  assign o_cmd_ready = (state_reg == ST_IDLE && !o_bus_busy) || state_reg == ST_HOLD;
  assign push  = state_reg == ST_HIGH && scl_s && cnt_done && rd_reg && bit_reg == 4'd8;
  assign flush = stop_det;  // RULE_09

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      bit_reg     <= '0;
      sh_reg      <= '0;
      rd_reg      <= 1'b0;
      nack_reg    <= 1'b0;
      own_reg     <= 1'b0;
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      o_done      <= 1'b0;
      o_got_nack  <= 1'b0;
      o_arb_lost  <= 1'b0;
      o_bus_error <= 1'b0;
    end else if (i_ce) begin
      o_done      <= 1'b0;
      o_arb_lost  <= 1'b0;
      o_bus_error <= 1'b0;
      if (!own_reg) cnt_reg <= '0;
      else if (!cnt_done) cnt_reg <= cnt_reg - 1'b1;
      case (state_reg)
        ST_IDLE: begin
          if (i_cmd_valid && o_cmd_ready && i_cmd == twi_pkg::CMD_START) begin
            sda_low_reg <= 1'b1;  // RULE_06
            own_reg     <= 1'b1;
            cnt_reg     <= CW'(twi_pkg::HIGH_CYC);
            state_reg   <= ST_START;
          end
        end
        ST_START: begin
          if (cnt_done) begin
            scl_low_reg <= 1'b1;
            o_done      <= 1'b1;
            state_reg   <= ST_HOLD;  // RULE_21
          end
        end
        ST_HOLD: begin
          // clock held low between bytes while awaiting a command
          if (i_cmd_valid) begin
            cnt_reg <= CW'(twi_pkg::LOW_CYC);
            case (i_cmd)
              twi_pkg::CMD_WRITE: begin
                sh_reg    <= i_cmd_data;
                rd_reg    <= 1'b0;
                bit_reg   <= '0;
                state_reg <= ST_LOW;
              end
              twi_pkg::CMD_READ: begin
                sh_reg    <= '0;
                rd_reg    <= 1'b1;
                nack_reg  <= i_cmd_nack || !fifo_ready;  // RULE_13 RULE_14
                bit_reg   <= '0;
                state_reg <= ST_LOW;
              end
              twi_pkg::CMD_STOP: begin
                sda_low_reg <= 1'b1;
                state_reg   <= ST_STOP0;
              end
              default: begin
                sda_low_reg <= 1'b0;
                state_reg   <= ST_RSTA;  // RULE_10
              end
            endcase
          end
        end
        ST_LOW: begin
          // data bits change only here, with the clock pulled low
          if (cnt_reg == CW'(twi_pkg::LOW_CYC / 2)) begin
            if (bit_reg == 4'd8) begin
              sda_low_reg <= rd_reg && !nack_reg;  // RULE_11 RULE_12
            end else begin
              sda_low_reg <= !rd_reg && !sh_reg[7];  // RULE_03 RULE_04
            end
          end
          if (cnt_done) begin
            scl_low_reg <= 1'b0;  // RULE_22
            cnt_reg     <= CW'(twi_pkg::HIGH_CYC);
            state_reg   <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // hold the count until the line really rises
          if (!scl_s) cnt_reg <= CW'(twi_pkg::HIGH_CYC);  // RULE_05 RULE_19
          if (lose) begin
            own_reg     <= 1'b0;  // RULE_20
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            o_arb_lost  <= 1'b1;
            state_reg   <= ST_IDLE;
          end else if (scl_s && (start_det || stop_det)) begin
            own_reg     <= 1'b0;  // RULE_02
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            o_bus_error <= 1'b1;
            state_reg   <= ST_IDLE;
          end else if (scl_s && cnt_done) begin
            scl_low_reg <= 1'b1;  // RULE_01
            cnt_reg     <= CW'(twi_pkg::LOW_CYC);
            if (bit_reg == 4'd8) begin
              o_got_nack <= sda_s;  // RULE_12 RULE_16
              o_done     <= 1'b1;
              state_reg  <= ST_HOLD;
            end else begin
              sh_reg    <= {sh_reg[6:0], sda_s};
              bit_reg   <= bit_reg + 4'd1;
              state_reg <= ST_LOW;
            end
          end
        end
        ST_RSTA: begin
          // release data, raise clock, then pull data low
          if (scl_low_reg) begin
            if (cnt_done) begin
              scl_low_reg <= 1'b0;
              cnt_reg     <= CW'(twi_pkg::HIGH_CYC);
            end
          end else if (!scl_s) begin
            // a stretched clock must not eat the setup time of the new start
            cnt_reg <= CW'(twi_pkg::HIGH_CYC);  // RULE_05
          end else if (cnt_done) begin
            sda_low_reg <= 1'b1;  // RULE_06
            cnt_reg     <= CW'(twi_pkg::HIGH_CYC);
            state_reg   <= ST_START;
          end
        end
        ST_STOP0: begin
          if (cnt_done) begin
            scl_low_reg <= 1'b0;
            cnt_reg     <= CW'(twi_pkg::HIGH_CYC);
            state_reg   <= ST_STOP1;
          end
        end
        ST_STOP1: begin
          if (!scl_s) cnt_reg <= CW'(twi_pkg::HIGH_CYC);  // RULE_05
          else if (cnt_done) begin
            sda_low_reg <= 1'b0;  // RULE_07
            own_reg     <= 1'b0;
            o_done      <= 1'b1;
            state_reg   <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // receive buffer and pins
  // ---------------------------------------------------------------------
  // a full buffer forces a nack on the next read; the byte still clocked in is dropped unless room frees first
  twi_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_flush (flush),
    .i_valid (push),
    .o_ready (fifo_ready),
    .i_data  (sh_reg),
    .o_valid (o_rx_valid),
    .i_ready (i_rx_ready),
    .o_data  (o_rx_data)
  );

  assign o_scl    = 1'b0;  // RULE_22
  assign o_sda    = 1'b0;  // RULE_22
  assign o_scl_oe = scl_low_reg;
  assign o_sda_oe = sda_low_reg;

  // general call is just a write of the zero address byte; no special path
  // RULE_15 RULE_17: address byte is formed by the user as {addr7, rw}
endmodule

// ---- rtl/twi_pkg.sv ----
// Purpose: shared constants for the two-wire bus master controller
// Assumes: 10 MHz system clock
// Notes:   times in ns, cycle counts derived from the clock period
package twi_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned SCL_LOW_NS      = 4700;
  localparam int unsigned SCL_HIGH_NS     = 4000;
  localparam int unsigned BUS_FREE_NS     = 4700;
  localparam int unsigned LOW_CYC         = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HIGH_CYC        = (SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FREE_CYC        = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BITS_PER_BYTE   = 8;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam logic [7:0]  GEN_CALL_ADDR   = 8'h00;
  localparam logic [1:0]  CMD_WRITE       = 2'h0;
  localparam logic [1:0]  CMD_READ        = 2'h1;
  localparam logic [1:0]  CMD_STOP        = 2'h2;
  localparam logic [1:0]  CMD_START       = 2'h3;
endpackage

// ---- rtl/twi_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: async input, active low reset
// Notes:   reset value is high, matching an idle pulled-up line
`timescale 1ns/10ps
module twi_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b1;
      o_q      <= 1'b1;
    end else if (i_ce) begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule

// ---- rtl/twi_fifo.sv ----
// Purpose: synchronous fifo for received bytes
// Assumes: single clock domain
// Notes:   depth must be a power of two
`timescale 1ns/10ps
module twi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign o_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign o_valid = wr_reg != rd_reg;
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rd_reg[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_reg[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (i_ce) begin
      if (i_flush) begin
        wr_reg <= '0;
        rd_reg <= '0;
      end else begin
        if (push) wr_reg <= wr_reg + 1'b1;
        if (pop)  rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule

// ---- tb/twi_slave_model.sv ----
// Purpose: behavioural slave on the two-wire bus
// Assumes: bus lines resolved by the bench with pull-ups
// Notes:   stretch holds the clock low 6 us after every fall
`timescale 1ns/10ps
module twi_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_tx,
  input  wire logic       i_stretch,
  output logic            o_scl_oe,
  output logic            o_sda_oe,
  output logic      [7:0] o_last
);
  int         cnt = 0;
  logic [7:0] sh = 8'h00;
  logic       first = 1'b0;
  logic       sel = 1'b0;
  logic       rd = 1'b0;
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    o_last = 8'h00;
  end
  always @(negedge i_sda) if (i_scl) begin
    cnt = 0;
    first = 1'b1;
    sel = 1'b0;
    rd = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) sel = 1'b0;
  always @(posedge i_scl) begin
    if (cnt < 8) sh = {sh[6:0], i_sda};
    if (cnt == 8 && rd && i_sda) sel = 1'b0;
    cnt = cnt + 1;
  end
  always @(negedge i_scl) begin
    if (cnt == 9) cnt = 0;
    if (cnt == 8) begin
      if (first) sel = (sh[7:1] == ADDR) || (sh == 8'h00);
      if (first) rd = sh[0] && sel;
      if (!first && !rd) o_last = sh;
      o_sda_oe = sel && (first || !rd);
      first = 1'b0;
    end else o_sda_oe = sel && rd && !i_tx[7-cnt];
    if (i_stretch) begin
      o_scl_oe = 1'b1;
      #6000;
      o_scl_oe = 1'b0;
    end
  end
endmodule

// ---- tb/twi_master_props.sv ----
// Purpose: pin-level checks for the two-wire master
// Assumes: i_scl and i_sda are the resolved bus lines
// Notes:   bounds allow for the two-flop input lag
`timescale 1ns/10ps
module twi_master_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic o_done,
  input wire logic o_arb_lost,
  input wire logic o_bus_error,
  input wire logic o_bus_busy,
  input wire logic o_rx_valid,
  input wire logic i_scl,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe
);
  localparam int HI = twi_pkg::HIGH_CYC;
  localparam int LO = twi_pkg::LOW_CYC - 1;
  int hi_reg;
  int lo_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) hi_reg <= 0;
    else hi_reg <= i_scl ? hi_reg + 1 : 0;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) lo_reg <= 0;
    else lo_reg <= o_scl_oe ? lo_reg + 1 : 0;
  end
  sequence s_start; $fell(i_sda) && i_scl; endsequence
  sequence s_stop; $rose(i_sda) && i_scl; endsequence
  sequence s_held; $fell(o_scl_oe) && !i_scl; endsequence
  sequence s_own_start; $rose(o_sda_oe) && !o_scl_oe && !$past(o_scl_oe); endsequence
  property p_od; o_scl == 1'b0 && o_sda == 1'b0; endproperty
  property p_start; s_own_start |-> ##[1:120] o_done; endproperty
  property p_held; s_held |=> !o_scl_oe [*8]; endproperty
  property p_high; $rose(o_scl_oe) |-> hi_reg >= HI; endproperty
  property p_low; $fell(o_scl_oe) |-> lo_reg >= LO; endproperty
  property p_busy_on; s_start |-> ##[1:6] o_bus_busy; endproperty
  property p_busy_hold; s_stop |=> o_bus_busy [*8]; endproperty
  property p_flush; s_stop |-> ##[1:8] !o_rx_valid; endproperty
  property p_arb; o_arb_lost |=> (!o_scl_oe && !o_sda_oe) [*4]; endproperty
  property p_berr; o_bus_error |=> (!o_scl_oe && !o_sda_oe) [*4]; endproperty
  a_od: assert property (p_od) else $error("line driven high");
  a_start: assert property (p_start) else $error("start not finished in time");
  a_held: assert property (p_held) else $error("clock pulled in stretch");
  a_high: assert property (p_high) else $error("clock high too short");
  a_low: assert property (p_low) else $error("clock low too short");
  a_busy_on: assert property (p_busy_on) else $error("busy missed start");
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped at stop");
  a_flush: assert property (p_flush) else $error("rx kept after stop");
  a_arb: assert property (p_arb) else $error("bus kept after loss");
  a_berr: assert property (p_berr) else $error("bus kept after bus error");
endmodule
bind twi_master twi_master_props u_props (.i_clk, .i_rst_n, .o_done, .o_arb_lost, .o_bus_error, .o_bus_busy,
  .o_rx_valid, .i_scl, .o_scl, .o_scl_oe, .i_sda, .o_sda, .o_sda_oe);

// ---- tb/test_twi_master.sv ----
// Purpose: self-checking bench for the two-wire master
// Assumes: one behavioural slave, pull-ups on both lines
// Notes:   a bench pull on the data line forces a lost arbitration or a bus error
`timescale 1ns/10ps
module test_twi_master;
  localparam logic [6:0] SLV = 7'h2a;
  logic       clk, rst_n, ce, cmd_valid, cmd_ready, cmd_nack, rx_valid, rx_ready;
  logic       done, got_nack, arb_lost, bus_busy, m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe;
  logic       tb_pull, stretch, berr;
  logic [1:0] cmd;
  logic [7:0] cmd_data, rx_data, tx, last;
  int         n_fail = 0;
  int         total_checks = 0;
  wire        scl = !(m_scl_oe || s_scl_oe);
  wire        sda = !(m_sda_oe || s_sda_oe || tb_pull);
  twi_master uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd(cmd), .i_cmd_data(cmd_data), .i_cmd_nack(cmd_nack), .o_rx_valid(rx_valid),
    .i_rx_ready(rx_ready), .o_rx_data(rx_data), .o_done(done), .o_got_nack(got_nack),
    .o_arb_lost(arb_lost), .o_bus_error(berr), .o_bus_busy(bus_busy), .i_scl(scl), .o_scl(),
    .o_scl_oe(m_scl_oe), .i_sda(sda), .o_sda(), .o_sda_oe(m_sda_oe));
  twi_slave_model #(.ADDR(SLV)) slave (.i_scl(scl), .i_sda(sda), .i_tx(tx), .i_stretch(stretch),
    .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe), .o_last(last));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic guard(input int k);
    if (k >= 3000) begin
      chk("wait_bound", 8'h00, 8'h01);
      conclude();
    end
  endtask
  task automatic run(input logic [1:0] c, input logic [7:0] d, input logic n);
    int k;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = c;
    cmd_data = d;
    cmd_nack = n;
    for (k = 0; cmd_ready !== 1'b1 && k < 3000; k++) @(negedge clk);
    guard(k);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (k = 0; done !== 1'b1 && arb_lost !== 1'b1 && k < 3000; k++) @(negedge clk);
    guard(k);
  endtask
  task automatic settle;
    repeat (twi_pkg::FREE_CYC + 5) @(negedge clk);
  endtask
  task automatic t_write;
    stretch = 1'b1;
    run(twi_pkg::CMD_START, 8'h00, 1'b0);
    run(twi_pkg::CMD_WRITE, {SLV, 1'b0}, 1'b0);
    chk("addr_ack", 8'h00, {7'h00, got_nack});
    run(twi_pkg::CMD_WRITE, 8'ha5, 1'b0);
    chk("write_ack", 8'h00, {7'h00, got_nack});
    chk("slave_byte", 8'ha5, last);
    run(twi_pkg::CMD_STOP, 8'h00, 1'b0);
    stretch = 1'b0;
    chk("busy_after_stop", 8'h01, {7'h00, bus_busy});
    settle;
    chk("busy_free", 8'h00, {7'h00, bus_busy});
    $display("test write done");
  endtask
  task automatic t_read;
    tx = 8'h3c;
    run(twi_pkg::CMD_START, 8'h00, 1'b0);
    run(twi_pkg::CMD_WRITE, {SLV, 1'b1}, 1'b0);
    chk("read_addr_ack", 8'h00, {7'h00, got_nack});
    run(twi_pkg::CMD_READ, 8'h00, 1'b0);
    chk("read_ack", 8'h00, {7'h00, got_nack});
    tx = 8'h5a;
    run(twi_pkg::CMD_READ, 8'h00, 1'b1);
    chk("read_last_nack", 8'h01, {7'h00, got_nack});
    chk("rx_valid", 8'h01, {7'h00, rx_valid});
    chk("rx_first", 8'h3c, rx_data);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    chk("rx_second", 8'h5a, rx_data);
    run(twi_pkg::CMD_START, 8'h00, 1'b0);
    run(twi_pkg::CMD_WRITE, {SLV, 1'b0}, 1'b0);
    chk("restart_ack", 8'h00, {7'h00, got_nack});
    run(twi_pkg::CMD_STOP, 8'h00, 1'b0);
    settle;
    chk("rx_flushed", 8'h00, {7'h00, rx_valid});
    $display("test read done");
  endtask
  task automatic t_addr(input logic [7:0] a, input logic e);
    run(twi_pkg::CMD_START, 8'h00, 1'b0);
    run(twi_pkg::CMD_WRITE, a, 1'b0);
    chk("addr_answer", {7'h00, e}, {7'h00, got_nack});
    if (!e) begin
      run(twi_pkg::CMD_WRITE, 8'h04, 1'b0);
      chk("call_byte", 8'h04, last);
    end
    run(twi_pkg::CMD_STOP, 8'h00, 1'b0);
    settle;
    $display("test address %h done", a);
  endtask
  task automatic t_berr;
    int k;
    tx = 8'hff;
    run(twi_pkg::CMD_START, 8'h00, 1'b0);
    run(twi_pkg::CMD_WRITE, {SLV, 1'b1}, 1'b0);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = twi_pkg::CMD_READ;
    cmd_nack = 1'b0;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (k = 0; scl !== 1'b1 && k < 3000; k++) @(negedge clk);
    guard(k);
    repeat (10) @(negedge clk);
    tb_pull = 1'b1;
    for (k = 0; berr !== 1'b1 && k < 20; k++) @(negedge clk);
    chk("bus_error", 8'h01, {7'h00, berr});
    repeat (2) @(negedge clk);
    chk("error_release", 8'h00, {6'h00, m_scl_oe, m_sda_oe});
    tb_pull = 1'b0;
    settle;
    $display("test bus error done");
  endtask
  task automatic t_arb;
    run(twi_pkg::CMD_START, 8'h00, 1'b0);
    tb_pull = 1'b1;
    run(twi_pkg::CMD_WRITE, 8'hfe, 1'b0);
    chk("arb_lost", 8'h01, {7'h00, arb_lost});
    repeat (2) @(negedge clk);
    chk("released", 8'h00, {6'h00, m_scl_oe, m_sda_oe});
    tb_pull = 1'b0;
    settle;
    $display("test arbitration done");
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd = 2'h0;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    rx_ready = 1'b0;
    tb_pull = 1'b0;
    stretch = 1'b0;
    tx = 8'h00;
    repeat (10) @(negedge clk);
    chk("reset_oe", 8'h00, {6'h00, m_scl_oe, m_sda_oe});
    rst_n = 1'b1;
    t_write;
    t_read;
    t_addr({7'h11, 1'b0}, 1'b1);
    t_addr(8'h00, 1'b0);
    t_berr;
    t_arb;
    conclude();
  end
endmodule
